// [rtl/inter_core_link.sv]
// Two-channel inter-core FIFO link with request/acknowledge bits, AXI4-Lite registers
`timescale 1ns/10ps
`include "link_params.svh"
// Function
// - Empty interrupt only on empty rising edge
// - Write clears empty, signals receiver data valid
// - Reset/disable forces empty, blocks empty interrupts
// - Two-bit threshold selects data-valid fill level
// - Write when full: overflow, data dropped
// - Read when empty: underflow, pointer holds
// - Empty interrupt once per empty transition
// - Data-valid held from threshold level until empty
// - Overflow/underflow faults interrupt both processors
// - Overflow sticky, transmitter clears it
// - Underflow sticky, receiver clears it
// - Crossings pass three destination-clock synchroniser
// - Write visible after one plus three clocks
// - Enables and flushing only from primary
// - Control bit 9 requests other-side interrupt
// - Control bit 8 acknowledges other's request
// - Requests/acks writable only by owner
// - Disable wipes storage, pointers, error flags
// - Write ports read zero, read ports ignore writes
// - Word or upper byte advances pointers
// - Re-setting set request gives no interrupt
module inter_core_link import link_pkg::*; #(
  parameter int DEPTH = `FIFO_DEPTH
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  input  wire logic        secondary_reset_n,
  output logic             primary_empty_irq,
  output logic             primary_data_valid_irq,
  output logic             primary_fault_irq,
  output logic             primary_ipc_irq,
  output logic             primary_srst_irq,
  output logic             secondary_empty_irq,
  output logic             secondary_data_valid_irq,
  output logic             secondary_fault_irq,
  output logic             secondary_ipc_irq
);
  localparam int LW = $clog2(DEPTH) + 1;

  function automatic logic mapped(input logic [7:0] a);
    return a inside {`PRI_CTRL_ADDR, `PRI_STAT_ADDR, `PRI_FCS_ADDR, `PRI_WR_PORT_ADDR,
                     `PRI_RD_PORT_ADDR, `SEC_CTRL_ADDR, `SEC_STAT_ADDR, `SEC_FCS_ADDR,
                     `SEC_WR_PORT_ADDR, `SEC_RD_PORT_ADDR};
  endfunction : mapped

  function automatic logic [LW-1:0] thr_level(input logic [1:0] sel);
    case (thresh_t'(sel))
      thr_first:         return LW'(1);
      thr_half:          return LW'(DEPTH / 2);
      thr_three_quarter: return LW'(3 * DEPTH / 4);
      thr_full:          return LW'(DEPTH);
      default:           return LW'(DEPTH);
    endcase
  endfunction : thr_level

  // Low byte staged by a lower-byte-only write, upper byte completes the word
  function automatic word_t merge_push(input logic [3:0] s, input logic [31:0] d,
                                       input logic [7:0] low);
    return s[0] ? d[15:0] : {d[15:8], low};
  endfunction : merge_push

  function automatic logic [31:0] ctl_word(input logic [1:0] thr, input logic req,
                                           input logic ack, input logic ie);
    logic [31:0] w;
    w = '0;
    w[`CTL_THR_HI:`CTL_THR_LO] = thr;
    w[`CTL_REQ] = req;
    w[`CTL_ACK] = ack;
    w[`CTL_SRST_IE] = ie;
    return w;
  endfunction : ctl_word

  // Field order: wr en/ovf/udf/full/empty, rd en/ovf/udf/full/empty
  function automatic logic [31:0] fcs_word(input logic [9:0] b);
    return {16'h0000, b[9], 3'h0, b[8:5], b[4], 3'h0, b[3:0]};
  endfunction : fcs_word

  // Bus holding registers
  logic [7:0]  aw_q;
  logic [31:0] wd_q;
  logic [3:0]  ws_q;
  logic        aw_held, w_held;
  // Control state
  logic [1:0]  pri_thr, sec_thr;
  logic        pri_req, pri_ack, srst_ie, sec_req, sec_ack;
  logic        wr_en, rd_en, srst_status;
  logic [7:0]  pri_low, sec_low;
  // Views from the other side
  logic        wr_en_sec, rd_en_sec;
  logic        pri_req_s, pri_ack_s, sec_req_s, sec_ack_s, pri_req_sq, sec_req_sq;
  logic        srst_n_s, srst_n_q;
  logic        w_tx_empty_q, r_tx_empty_q;
  // Channel signals (w: primary to secondary, r: secondary to primary)
  word_t       w_pop_data, r_pop_data;
  logic        w_tx_empty, w_tx_full, w_rx_empty, w_rx_full, w_ovf, w_udf, w_ovf_rv, w_udf_tv;
  logic        r_tx_empty, r_tx_full, r_rx_empty, r_rx_full, r_ovf, r_udf, r_ovf_rv, r_udf_tv;
  logic [LW-1:0] w_rx_level, r_rx_level;

  // Write channel decode
  wire         wr_fire = aw_held && w_held && !bvalid;
  wire [7:0]   wa      = {aw_q[7:2], 2'h0};
  wire         ln0     = ws_q[0];
  wire         ln1     = ws_q[1];
  wire         w_pctl  = wr_fire && (wa == `PRI_CTRL_ADDR);
  wire         w_pstat = wr_fire && (wa == `PRI_STAT_ADDR);
  wire         w_pfcs  = wr_fire && (wa == `PRI_FCS_ADDR);
  wire         w_pwp   = wr_fire && (wa == `PRI_WR_PORT_ADDR);
  wire         w_sctl  = wr_fire && (wa == `SEC_CTRL_ADDR);
  wire         w_sfcs  = wr_fire && (wa == `SEC_FCS_ADDR);
  wire         w_swp   = wr_fire && (wa == `SEC_WR_PORT_ADDR);
  wire         p_push  = w_pwp && ln1;
  wire         s_push  = w_swp && ln1;
  wire         w_ovf_clr = w_pfcs && ln1 && wd_q[`FCS_WR_OVF];
  wire         r_udf_clr = w_pfcs && ln0 && wd_q[`FCS_RD_UDF];
  wire         w_udf_clr = w_sfcs && ln1 && wd_q[`FCS_WR_UDF];
  wire         r_ovf_clr = w_sfcs && ln0 && wd_q[`FCS_RD_OVF];
  wire         srst_clr  = w_pstat && ln1 && wd_q[`STAT_SRST];

  // Read channel decode
  wire         rd_fire = arvalid && arready;
  wire [7:0]   ra      = {araddr[7:2], 2'h0};
  wire         p_pop   = rd_fire && (ra == `PRI_RD_PORT_ADDR);
  wire         s_pop   = rd_fire && (ra == `SEC_RD_PORT_ADDR);
  wire [31:0]  p_fcs   = fcs_word({wr_en, w_ovf, w_udf_tv, w_tx_full, w_tx_empty,
                                   rd_en, r_ovf_rv, r_udf, r_rx_full, r_rx_empty});
  wire [31:0]  s_fcs   = fcs_word({wr_en_sec, w_ovf_rv, w_udf, w_rx_full, w_rx_empty,
                                   rd_en_sec, r_ovf, r_udf_tv, r_tx_full, r_tx_empty});
  wire [31:0]  p_stat  = {16'h0000, srst_status, 5'h00, sec_req_s, pri_ack_s, 8'h00};
  wire [31:0]  s_stat  = {16'h0000, 6'h00, pri_req_s, sec_ack_s, 8'h00};
  // Write ports and unmapped offsets read as zero
  wire [31:0]  rd_word =
    (ra == `PRI_CTRL_ADDR)    ? ctl_word(pri_thr, pri_req, pri_ack, srst_ie) :
    (ra == `PRI_STAT_ADDR)    ? p_stat :
    (ra == `PRI_FCS_ADDR)     ? p_fcs :
    (ra == `PRI_RD_PORT_ADDR) ? {16'h0000, r_pop_data} :
    (ra == `SEC_CTRL_ADDR)    ? ctl_word(sec_thr, sec_req, sec_ack, 1'b0) :
    (ra == `SEC_STAT_ADDR)    ? s_stat :
    (ra == `SEC_FCS_ADDR)     ? s_fcs :
    (ra == `SEC_RD_PORT_ADDR) ? {16'h0000, w_pop_data} : 32'h0000_0000;

  assign awready = !aw_held && !bvalid;
  assign wready  = !w_held && !bvalid;
  assign arready = !rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      bvalid  <= 1'b0;
      bresp   <= `RESP_OKAY;
      aw_q    <= 8'h00;
      wd_q    <= 32'h0000_0000;
      ws_q    <= 4'h0;
    end else begin
      if (awvalid && awready) begin
        aw_held <= 1'b1;
        aw_q    <= awaddr;
      end
      if (wvalid && wready) begin
        w_held <= 1'b1;
        wd_q   <= wdata;
        ws_q   <= wstrb;
      end
      if (wr_fire) begin
        aw_held <= 1'b0;
        w_held  <= 1'b0;
        bvalid  <= 1'b1;
        bresp   <= mapped(wa) ? `RESP_OKAY : `RESP_SLVERR;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata  <= 32'h0000_0000;
      rresp  <= `RESP_OKAY;
    end else if (rd_fire) begin
      rvalid <= 1'b1;
      rdata  <= rd_word;
      rresp  <= mapped(ra) ? `RESP_OKAY : `RESP_SLVERR;
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end

  // Each side writes only its own request, acknowledge and selector bits
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {pri_thr, pri_req, pri_ack, srst_ie} <= 5'h00;
      {sec_thr, sec_req, sec_ack} <= 4'h0;
      {wr_en, rd_en} <= 2'h0;
      pri_low <= 8'h00;
      sec_low <= 8'h00;
    end else begin
      if (w_pctl && ln1) {pri_thr, pri_req, pri_ack} <= wd_q[`CTL_THR_HI:`CTL_ACK];
      if (w_pctl && ln0) srst_ie <= wd_q[`CTL_SRST_IE];
      if (w_sctl && ln1) {sec_thr, sec_req, sec_ack} <= wd_q[`CTL_THR_HI:`CTL_ACK];
      if (w_pfcs && ln1) wr_en <= wd_q[`FCS_WR_EN];
      if (w_pfcs && ln0) rd_en <= wd_q[`FCS_RD_EN];
      if (w_pwp && ln0 && !ln1) pri_low <= wd_q[7:0];
      if (w_swp && ln0 && !ln1) sec_low <= wd_q[7:0];
    end
  end

  // Sticky secondary-reset status, set on the reset edge; set wins over clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      srst_n_q         <= 1'b0;
      srst_status      <= 1'b0;
      primary_srst_irq <= 1'b0;
    end else begin
      srst_n_q         <= srst_n_s;
      srst_status      <= (srst_n_q && !srst_n_s) || (srst_status && !srst_clr);
      primary_srst_irq <= srst_ie && srst_n_q && !srst_n_s;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_tx_empty_q <= 1'b1;
      r_tx_empty_q <= 1'b1;
      primary_empty_irq        <= 1'b0;
      secondary_empty_irq      <= 1'b0;
      primary_data_valid_irq   <= 1'b0;
      secondary_data_valid_irq <= 1'b0;
      pri_req_sq        <= 1'b0;
      sec_req_sq        <= 1'b0;
      primary_ipc_irq   <= 1'b0;
      secondary_ipc_irq <= 1'b0;
    end else begin
      w_tx_empty_q <= w_tx_empty;
      r_tx_empty_q <= r_tx_empty;
      primary_empty_irq   <= wr_en && w_tx_empty && !w_tx_empty_q;
      secondary_empty_irq <= rd_en_sec && r_tx_empty && !r_tx_empty_q;
      primary_data_valid_irq <= !r_rx_empty &&
        (primary_data_valid_irq || r_rx_level >= thr_level(pri_thr));
      secondary_data_valid_irq <= !w_rx_empty &&
        (secondary_data_valid_irq || w_rx_level >= thr_level(sec_thr));
      pri_req_sq        <= pri_req_s;
      sec_req_sq        <= sec_req_s;
      secondary_ipc_irq <= pri_req_s && !pri_req_sq;
      primary_ipc_irq   <= sec_req_s && !sec_req_sq;
    end
  end

  assign primary_fault_irq   = w_ovf || w_udf_tv || r_ovf_rv || r_udf;
  assign secondary_fault_irq = w_ovf_rv || w_udf || r_ovf || r_udf_tv;

  sync3 #(.WIDTH(2)) u_en_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .d       ({wr_en, rd_en}),
    .q       ({wr_en_sec, rd_en_sec})
  );
  sync3 #(.WIDTH(4)) u_ipc_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .d       ({pri_req, sec_ack, sec_req, pri_ack}),
    .q       ({pri_req_s, pri_ack_s, sec_req_s, sec_ack_s})
  );
  sync3 #(.WIDTH(1)) u_srst_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .d       (secondary_reset_n),
    .q       (srst_n_s)
  );

  fifo_channel #(.DEPTH(DEPTH)) u_wr_chan (
    .aclk        (aclk),
    .aresetn     (aresetn),
    .enable_tx   (wr_en),
    .enable_rx   (wr_en_sec),
    .push        (p_push),
    .push_data   (merge_push(ws_q, wd_q, pri_low)),
    .pop         (s_pop),
    .ovf_clr     (w_ovf_clr),
    .udf_clr     (w_udf_clr),
    .pop_data    (w_pop_data),
    .tx_empty    (w_tx_empty),
    .tx_full     (w_tx_full),
    .rx_empty    (w_rx_empty),
    .rx_full     (w_rx_full),
    .rx_level    (w_rx_level),
    .ovf         (w_ovf),
    .udf         (w_udf),
    .ovf_rx_view (w_ovf_rv),
    .udf_tx_view (w_udf_tv)
  );

  fifo_channel #(.DEPTH(DEPTH)) u_rd_chan (
    .aclk        (aclk),
    .aresetn     (aresetn),
    .enable_tx   (rd_en_sec),
    .enable_rx   (rd_en),
    .push        (s_push),
    .push_data   (merge_push(ws_q, wd_q, sec_low)),
    .pop         (p_pop),
    .ovf_clr     (r_ovf_clr),
    .udf_clr     (r_udf_clr),
    .pop_data    (r_pop_data),
    .tx_empty    (r_tx_empty),
    .tx_full     (r_tx_full),
    .rx_empty    (r_rx_empty),
    .rx_full     (r_rx_full),
    .rx_level    (r_rx_level),
    .ovf         (r_ovf),
    .udf         (r_udf),
    .ovf_rx_view (r_ovf_rv),
    .udf_tx_view (r_udf_tv)
  );

  empty_irq_edge_a: assert property (@(posedge aclk) disable iff (!aresetn)
    primary_empty_irq |-> $past(w_tx_empty) && !$past(w_tx_empty, 2))
    else $error("empty interrupt without rising empty flag");
  disabled_no_irq_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !wr_en |=> !primary_empty_irq) else $error("empty interrupt while disabled");
  data_valid_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    primary_data_valid_irq && !r_rx_empty |=> primary_data_valid_irq)
    else $error("data valid dropped before empty");
  sequence s_ovf_rise;
    $rose(w_ovf);
  endsequence
  fault_both_sides_a: assert property (@(posedge aclk) disable iff (!aresetn)
    s_ovf_rise |-> primary_fault_irq ##3 secondary_fault_irq)
    else $error("fault not seen by both processors");
  rd_fault_both_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(r_ovf) |-> secondary_fault_irq ##3 primary_fault_irq)
    else $error("read channel fault not seen by both processors");
  ipc_latency_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(pri_req) |-> ##4 secondary_ipc_irq) else $error("request interrupt late or missing");
  ipc_single_a: assert property (@(posedge aclk) disable iff (!aresetn)
    secondary_ipc_irq |=> (!secondary_ipc_irq)[*2]) else $error("repeated request interrupt");
  enable_owner_a: assert property (@(posedge aclk) disable iff (!aresetn)
    w_sfcs |=> $stable(wr_en) && $stable(rd_en)) else $error("secondary changed an enable");
endmodule : inter_core_link

// [rtl/link_params.svh]
// Register offsets, field positions and timing counts of the inter-core link
`ifndef LINK_PARAMS_SVH
`define LINK_PARAMS_SVH
`define PRI_CTRL_ADDR    8'h00
`define PRI_STAT_ADDR    8'h04
`define PRI_FCS_ADDR     8'h08
`define PRI_WR_PORT_ADDR 8'h0C
`define PRI_RD_PORT_ADDR 8'h10
`define SEC_CTRL_ADDR    8'h20
`define SEC_STAT_ADDR    8'h24
`define SEC_FCS_ADDR     8'h28
`define SEC_WR_PORT_ADDR 8'h2C
`define SEC_RD_PORT_ADDR 8'h30
`define CTL_THR_HI       11
`define CTL_THR_LO       10
`define CTL_REQ          9
`define CTL_ACK          8
`define CTL_SRST_IE      7
`define STAT_SRST        15
`define FCS_WR_EN        15
`define FCS_WR_OVF       11
`define FCS_WR_UDF       10
`define FCS_RD_EN        7
`define FCS_RD_OVF       3
`define FCS_RD_UDF       2
`define SYNC_STAGES      3
`define FIFO_DEPTH       32
`define RESP_OKAY        2'h0
`define RESP_SLVERR      2'h2
`endif

// [rtl/link_pkg.sv]
// Types shared by the inter-core link modules
package link_pkg;
  typedef logic [15:0] word_t;
  typedef enum logic [1:0] {thr_first, thr_half, thr_three_quarter, thr_full} thresh_t;
endpackage : link_pkg

// [rtl/sync3.sv]
// Multi-stage synchroniser for levels and gray-coded words
`timescale 1ns/10ps
`include "link_params.svh"
module sync3 #(
  parameter int WIDTH  = 1,
  parameter int STAGES = `SYNC_STAGES
) (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);
  logic [WIDTH-1:0] stage [STAGES];

  if (STAGES < 2) begin : g_bad_stages
    $error("sync3 needs at least two stages");
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < STAGES; i++) stage[i] <= '0;
    end else begin
      stage[0] <= d;
      for (int i = 1; i < STAGES; i++) stage[i] <= stage[i-1];
    end
  end

  assign q = stage[STAGES-1];
endmodule : sync3

// [rtl/fifo_channel.sv]
// One unidirectional channel: storage, gray pointers, occupancy and error flags
`timescale 1ns/10ps
`include "link_params.svh"
module fifo_channel import link_pkg::*; #(
  parameter int DEPTH = `FIFO_DEPTH
) (
  input  wire logic                     aclk,
  input  wire logic                     aresetn,
  input  wire logic                     enable_tx,
  input  wire logic                     enable_rx,
  input  wire logic                     push,
  input  wire word_t                    push_data,
  input  wire logic                     pop,
  input  wire logic                     ovf_clr,
  input  wire logic                     udf_clr,
  output word_t                         pop_data,
  output logic                          tx_empty,
  output logic                          tx_full,
  output logic                          rx_empty,
  output logic                          rx_full,
  output logic [$clog2(DEPTH):0]        rx_level,
  output logic                          ovf,
  output logic                          udf,
  output logic                          ovf_rx_view,
  output logic                          udf_tx_view
);
  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 4 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("fifo_channel depth must be a power of two of at least four");
  end

  function automatic logic [AW:0] to_gray(input logic [AW:0] b);
    return b ^ (b >> 1);
  endfunction : to_gray

  function automatic logic [AW:0] to_bin(input logic [AW:0] g);
    logic [AW:0] b;
    b[AW] = g[AW];
    for (int i = AW - 1; i >= 0; i--) b[i] = b[i+1] ^ g[i];
    return b;
  endfunction : to_bin

  word_t          mem [DEPTH];
  logic [AW:0]    wptr, rptr, wgray, rgray, wgray_s, rgray_s;
  logic [AW:0]    tx_used;
  logic [AW-1:0]  last_idx;
  logic           wr_ok, rd_ok, ovf_set, udf_set;

  assign tx_used  = wptr - to_bin(rgray_s);
  assign tx_full  = enable_tx && (tx_used == (AW+1)'(DEPTH));
  assign tx_empty = !enable_tx || (wptr == to_bin(rgray_s));
  assign rx_level = enable_rx ? (to_bin(wgray_s) - rptr) : '0;
  assign rx_empty = (rx_level == '0);
  assign rx_full  = (rx_level == (AW+1)'(DEPTH));
  assign wr_ok    = enable_tx && push && !tx_full;
  assign ovf_set  = enable_tx && push && tx_full;
  assign rd_ok    = enable_rx && pop && !rx_empty;
  assign udf_set  = enable_rx && pop && rx_empty;
  assign last_idx = rptr[AW-1:0] - 1'b1;
  // An empty read returns the location read last
  assign pop_data = rx_empty ? mem[last_idx] : mem[rptr[AW-1:0]];

  always_ff @(posedge aclk) begin
    if (!aresetn || !enable_tx) begin
      for (int i = 0; i < DEPTH; i++) mem[i] <= '0;
      wptr  <= '0;
      wgray <= '0;
    end else if (wr_ok) begin
      mem[wptr[AW-1:0]] <= push_data;
      wptr  <= wptr + 1'b1;
      wgray <= to_gray(wptr + 1'b1);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || !enable_tx) begin
      ovf <= 1'b0;
    end else if (ovf_set) begin
      ovf <= 1'b1;
    end else if (ovf_clr) begin
      ovf <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || !enable_rx) begin
      rptr  <= '0;
      rgray <= '0;
      udf   <= 1'b0;
    end else begin
      if (rd_ok) begin
        rptr  <= rptr + 1'b1;
        rgray <= to_gray(rptr + 1'b1);
      end
      if (udf_set) udf <= 1'b1;
      else if (udf_clr) udf <= 1'b0;
    end
  end

  sync3 #(.WIDTH(AW + 1)) u_wsync (.aclk(aclk), .aresetn(aresetn), .d(wgray), .q(wgray_s));
  sync3 #(.WIDTH(AW + 1)) u_rsync (.aclk(aclk), .aresetn(aresetn), .d(rgray), .q(rgray_s));
  sync3 #(.WIDTH(2)) u_fsync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .d       ({ovf, udf}),
    .q       ({ovf_rx_view, udf_tx_view})
  );

  property p_ovf_keeps;
    @(posedge aclk) disable iff (!aresetn)
      ovf_set |=> ovf && $stable(wptr) && $stable(mem[wptr[AW-1:0]]);
  endproperty
  ovf_write_drop_a: assert property (p_ovf_keeps) else $error("overflow write altered channel");
  underflow_reread_a: assert property (@(posedge aclk) disable iff (!aresetn)
    udf_set |=> udf && $stable(rptr)) else $error("underflow moved read pointer");
  sequence s_word_in;
    wr_ok && enable_rx && rx_empty;
  endsequence
  write_latency_a: assert property (@(posedge aclk) disable iff (!aresetn)
    s_word_in ##1 (enable_tx && enable_rx)[*4] |-> $past(rx_empty) && !rx_empty)
    else $error("word not visible four cycles after write");
  disable_flush_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !enable_tx |=> wptr == '0 && !ovf && tx_empty) else $error("disable did not flush");
endmodule : fifo_channel

// [testbench/sec_core_model.sv]
// Secondary core model: owns the secondary reset pin
`timescale 1ns/10ps
module sec_core_model (
  input  wire logic aclk,
  output logic      secondary_reset_n
);
  initial secondary_reset_n = 1'b1;
  // Secondary restart, seen by the primary as a low pulse
  task automatic pulse_reset();
    @(posedge aclk);
    secondary_reset_n <= 1'b0;
    repeat (4) @(posedge aclk);
    secondary_reset_n <= 1'b1;
  endtask : pulse_reset
endmodule : sec_core_model

// [testbench/inter_core_link_test.sv]
// Self-checking bench for the two-channel inter-core link
`timescale 1ns/10ps
`include "link_params.svh"
module inter_core_link_test;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, rv;
  logic [3:0]  wstrb = 4'h3;
  logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic        awready, wready, bvalid, arready, rvalid, secondary_reset_n;
  logic [1:0]  bresp, rresp, rs;
  logic        p_e, p_d, p_f, p_i, p_s, s_e, s_d, s_f, s_i;
  int          error_cnt = 0, checks_done = 0, pulses, pe_cnt, pi_cnt, ps_cnt, se_cnt;
  always #5 aclk = ~aclk;
  inter_core_link #(.DEPTH(8)) u_dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .secondary_reset_n(secondary_reset_n), .primary_empty_irq(p_e),
    .primary_data_valid_irq(p_d), .primary_fault_irq(p_f), .primary_ipc_irq(p_i),
    .primary_srst_irq(p_s), .secondary_empty_irq(s_e), .secondary_data_valid_irq(s_d),
    .secondary_fault_irq(s_f), .secondary_ipc_irq(s_i));
  sec_core_model u_sec (.aclk(aclk), .secondary_reset_n(secondary_reset_n));
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // Counts interrupt pulses over n cycles, sampled at the falling edge
  task automatic watch(input int n);
    pulses = 0;
    pe_cnt = 0;
    pi_cnt = 0;
    ps_cnt = 0;
    se_cnt = 0;
    repeat (n) begin
      @(negedge aclk);
      if (s_i === 1'b1) pulses++;
      if (p_e === 1'b1) pe_cnt++;
      if (p_i === 1'b1) pi_cnt++;
      if (p_s === 1'b1) ps_cnt++;
      if (s_e === 1'b1) se_cnt++;
    end
  endtask : watch
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : report_and_stop
  // One AXI4-Lite write (w=1) or read (w=0); answer lands in rv and rs
  task automatic axi(input logic w, input logic [7:0] a, input logic [31:0] d);
    logic ha, hw, hr, dn;
    int   n;
    dn = 1'b0;
    n = 0;
    @(posedge aclk);
    if (w) begin
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
    end else begin
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
    end
    while (!dn && n < 50) begin
      @(negedge aclk);
      ha = awvalid && awready;
      hw = wvalid && wready;
      hr = arvalid && arready;
      dn = w ? bvalid : rvalid;
      rv = rdata;
      rs = w ? bresp : rresp;
      @(posedge aclk);
      if (ha) awvalid <= 1'b0;
      if (hw) wvalid <= 1'b0;
      if (hr) arvalid <= 1'b0;
      n++;
    end
    bready <= 1'b0;
    rready <= 1'b0;
    if (!dn) begin
      error_cnt++;
      report_and_stop();
    end
  endtask : axi
  task automatic t_reset();
    axi(0, `PRI_FCS_ADDR, 0);
    chk("fcs after reset", rv, 32'h0101);
    axi(0, `PRI_WR_PORT_ADDR, 0);
    chk("write port read", rv, 32'h0);
    axi(0, 8'hFC, 0);
    chk("unmapped resp", rs, `RESP_SLVERR);
    $display("test reset done");
  endtask : t_reset
  task automatic t_flow();
    axi(1, `PRI_FCS_ADDR, 32'h8000);
    axi(1, `PRI_WR_PORT_ADDR, 32'hA5C3);
    repeat (8) @(posedge aclk);
    chk("data valid", s_d, 1);
    axi(0, `SEC_RD_PORT_ADDR, 0);
    chk("popped word", rv, 32'hA5C3);
    axi(0, `SEC_RD_PORT_ADDR, 0);
    chk("reread word", rv, 32'hA5C3);
    watch(8);
    chk("empty irq pulses", pe_cnt, 1);
    chk("pri fault", p_f, 1);
    chk("sec fault", s_f, 1);
    chk("data valid off", s_d, 0);
    axi(0, `PRI_FCS_ADDR, 0);
    chk("udf view", rv[10], 1);
    axi(1, `SEC_FCS_ADDR, 32'h0400);
    repeat (8) @(posedge aclk);
    chk("sec fault clr", s_f, 0);
    axi(1, `PRI_FCS_ADDR, 0);
    axi(0, `PRI_FCS_ADDR, 0);
    chk("fcs flushed", rv, 32'h0101);
    $display("test flow done");
  endtask : t_flow
  task automatic t_ipc();
    for (int k = 0; k < 2; k++) begin
      axi(1, `PRI_CTRL_ADDR, 32'h0200);
      watch(10);
      chk("ipc pulses", pulses, k == 0);
    end
    axi(1, `SEC_CTRL_ADDR, 32'h0200);
    watch(10);
    chk("pri ipc pulses", pi_cnt, 1);
    axi(1, `PRI_CTRL_ADDR, 32'h0300);
    watch(6);
    chk("no second request irq", pulses, 0);
    axi(0, `SEC_STAT_ADDR, 0);
    chk("req view", rv, 32'h0300);
    axi(0, `PRI_STAT_ADDR, 0);
    chk("sec req view", rv, 32'h0200);
    $display("test ipc done");
  endtask : t_ipc
  task automatic t_fill();
    axi(1, `PRI_CTRL_ADDR, 32'h0400);
    axi(1, `PRI_FCS_ADDR, 32'h0080);
    for (int i = 1; i <= 9; i++) begin
      axi(1, `SEC_WR_PORT_ADDR, i);
      watch(6);
      chk("dv at half", p_d, i >= 4);
    end
    axi(0, `PRI_FCS_ADDR, 0);
    chk("fcs full ovf", rv, 32'h018A);
    axi(0, `SEC_FCS_ADDR, 0);
    chk("sec fcs full ovf", rv, 32'h018A);
    chk("pri fault ovf", p_f, 1);
    chk("sec fault ovf", s_f, 1);
    for (int i = 1; i <= 8; i++) begin
      chk("dv held", p_d, 1);
      axi(0, `PRI_RD_PORT_ADDR, 0);
      chk("fifo word", rv, i);
    end
    watch(8);
    chk("sec empty irq pulses", se_cnt, 1);
    chk("dv off", p_d, 0);
    axi(1, `SEC_FCS_ADDR, 32'h0008);
    watch(6);
    chk("pri ovf cleared", p_f, 0);
    chk("sec ovf cleared", s_f, 0);
    @(posedge aclk);
    wstrb <= 4'h1;
    axi(1, `SEC_WR_PORT_ADDR, 32'h0034);
    wstrb <= 4'h2;
    axi(1, `SEC_WR_PORT_ADDR, 32'h1200);
    wstrb <= 4'h3;
    watch(6);
    axi(0, `PRI_RD_PORT_ADDR, 0);
    chk("byte pair word", rv, 32'h1234);
    $display("test fill done");
  endtask : t_fill
  task automatic t_srst();
    axi(1, `PRI_CTRL_ADDR, 32'h0080);
    u_sec.pulse_reset();
    watch(8);
    chk("srst irq pulses", ps_cnt, 1);
    axi(0, `PRI_STAT_ADDR, 0);
    chk("srst status", rv[15], 1);
    axi(1, `PRI_STAT_ADDR, 32'h0000_8000);
    axi(0, `PRI_STAT_ADDR, 0);
    chk("srst status clear", rv[15], 0);
    $display("test srst done");
  endtask : t_srst
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_flow();
    t_ipc();
    t_fill();
    t_srst();
    report_and_stop();
  end
endmodule : inter_core_link_test
